// >>> design/smt_count.sv
`timescale 1ns/1ns
module smt_count (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// control
	input  wire logic        advance,
	input  wire logic        load,
	input  wire logic [15:0] load_value,
	input  wire logic [15:0] compare,
	// state
	output wire logic [15:0] count,
	output wire logic        match_pulse
);

	typedef struct packed {
		logic [15:0] count;
		logic        match;
	} smt_count_s;

	smt_count_s st_r;
	smt_count_s st_nxt;

	always_comb begin
		st_nxt       = st_r;
		st_nxt.match = 1'b0;
		if (load) begin
			st_nxt.count = load_value;
		end else if (advance) begin
			if (st_r.count == compare) begin
				st_nxt.count = smt_pkg::COUNT_RST;
				st_nxt.match = 1'b1;
			end else begin
				st_nxt.count = st_r.count + 16'h0001;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '{count: smt_pkg::COUNT_RST, match: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign count       = st_r.count;
	assign match_pulse = st_r.match;

endmodule : smt_count

// >>> design/smt_sync.sv
`timescale 1ns/1ns
module smt_sync (
	// clock and reset
	input  wire logic                        sys_clk,
	input  wire logic                        rst_n,
	// levels from outside the clock domain
	input  wire logic [smt_pkg::SYNC_W-1:0] async_in,
	output wire logic [smt_pkg::SYNC_W-1:0] sync_out
);

	typedef struct packed {
		logic [smt_pkg::SYNC_W-1:0] stage1;
		logic [smt_pkg::SYNC_W-1:0] stage2;
	} smt_sync_s;

	smt_sync_s st_r;
	smt_sync_s st_nxt;

	always_comb begin
		st_nxt        = st_r;
		st_nxt.stage1 = async_in;
		st_nxt.stage2 = st_r.stage1;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign sync_out = st_r.stage2;

endmodule : smt_sync

// >>> design/smt_top.sv
`timescale 1ns/1ns
// Behaviour
// - halt-stop bit pauses counting during debug halt
// - idle-keep bit zero pauses counting in idle
// - toggle enable inverts output on each match
// - force field inverts, sets, clears; reads 11
// - clock select picks system or prescaled clock
// - count up, wrap to zero on match
// - match interrupt pulse on every match
// - output resets low, holds while stopped unless forced or toggled by a final match pulse
// - readback shows live count; write loads it
module smt_top (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// avalon-mm slave
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output wire logic [31:0] avs_readdata,
	output wire logic        avs_waitrequest,
	// system state and prescaled clock
	input  wire logic        idle_mode,
	input  wire logic        debug_halt,
	input  wire logic        periph_clk_prescaled,
	// timer outputs
	output wire logic        square_wave_output,
	output wire logic        match_interrupt
);

	typedef struct packed {
		smt_pkg::smt_bus_e bus;
		logic [31:0]       rdata;
		logic              idle_keep;
		logic              halt_stop;
		logic              run;
		logic              toggle_en;
		logic              clk_sel;
		logic [15:0]       compare;
		logic              sq_out;
		logic              tick_prev;
	} smt_top_s;

	localparam smt_top_s SMT_TOP_RST = '{
		bus:       smt_pkg::BUS_IDLE,
		rdata:     32'h00000000,
		idle_keep: smt_pkg::IDLE_KEEP_RST,
		halt_stop: smt_pkg::HALT_STOP_RST,
		run:       smt_pkg::RUN_RST,
		toggle_en: smt_pkg::TOGGLE_EN_RST,
		clk_sel:   smt_pkg::CLK_SEL_RST,
		compare:   smt_pkg::COMPARE_RST,
		sq_out:    smt_pkg::SQ_OUT_RST,
		tick_prev: 1'b0
	};

	smt_top_s st_r;
	smt_top_s st_nxt;

	// synchronised outside levels
	logic [smt_pkg::SYNC_W-1:0] sync_q;
	logic                       idle_s;
	logic                       halt_s;
	logic                       pclk_s;

	smt_sync u_sync (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.async_in ({periph_clk_prescaled, debug_halt, idle_mode}),
		.sync_out (sync_q)
	);

	assign idle_s = sync_q[0];
	assign halt_s = sync_q[1];
	assign pclk_s = sync_q[2];

	// bus decode
	logic        req;
	logic        acc;
	logic        wr_acc;
	logic        hit_en;
	logic        hit_run;
	logic        hit_cr;
	logic        hit_cmp;
	logic        hit_cnt;
	logic        lane0_wr;
	logic        lane1_wr;
	logic [1:0]  force_code;
	logic        force_wr;
	logic        ld_count;
	logic [15:0] ld_value;
	logic [31:0] rd_word;

	assign req             = avs_read | avs_write;
	assign acc             = req & (st_r.bus == smt_pkg::BUS_ACK);
	assign avs_waitrequest = req & (st_r.bus != smt_pkg::BUS_ACK);
	assign wr_acc          = avs_write & acc;
	assign lane0_wr        = wr_acc & avs_byteenable[0];
	assign lane1_wr        = wr_acc & avs_byteenable[1];

	assign hit_en  = avs_address == smt_pkg::ADDR_POWER_STATE;
	assign hit_run = avs_address == smt_pkg::ADDR_RUN_CONTROL;
	assign hit_cr  = avs_address == smt_pkg::ADDR_OUT_CLK_CTRL;
	assign hit_cmp = avs_address == smt_pkg::ADDR_COMPARE;
	assign hit_cnt = avs_address == smt_pkg::ADDR_COUNT;

	assign force_code = avs_writedata[smt_pkg::FORCE_HI_BIT:
		smt_pkg::FORCE_LO_BIT];
	assign force_wr   = lane0_wr & hit_cr &
		(force_code != smt_pkg::FORCE_NOP);

	// counter source and pause conditions
	logic        idle_block;
	logic        halt_block;
	logic        src_tick;
	logic        cnt_adv;
	logic [15:0] count_val;

	assign idle_block = idle_s & ~st_r.idle_keep;
	assign halt_block = halt_s & st_r.halt_stop;
	assign src_tick   = st_r.clk_sel ?
		(pclk_s & ~st_r.tick_prev) : 1'b1;
	assign cnt_adv    = st_r.run & src_tick & ~idle_block &
		~halt_block & ~ld_count;

	// software load keeps unwritten bytes
	assign ld_count = (lane0_wr | lane1_wr) & hit_cnt;
	assign ld_value = {
		avs_byteenable[1] ? avs_writedata[15:8] : count_val[15:8],
		avs_byteenable[0] ? avs_writedata[7:0] : count_val[7:0]
	};

	smt_count u_count (
		.sys_clk     (sys_clk),
		.rst_n       (rst_n),
		.advance     (cnt_adv),
		.load        (ld_count),
		.load_value  (ld_value),
		.compare     (st_r.compare),
		.count       (count_val),
		.match_pulse (match_interrupt)
	);

	// read mux, unmapped reads as zero
	always_comb begin
		rd_word = 32'h00000000;
		case (avs_address)
			smt_pkg::ADDR_POWER_STATE: begin
				rd_word[smt_pkg::IDLE_KEEP_BIT] = st_r.idle_keep;
				rd_word[smt_pkg::HALT_STOP_BIT] = st_r.halt_stop;
			end
			smt_pkg::ADDR_RUN_CONTROL: begin
				rd_word[smt_pkg::RUN_BIT] = st_r.run;
			end
			smt_pkg::ADDR_OUT_CLK_CTRL: begin
				rd_word[smt_pkg::TOGGLE_EN_BIT] = st_r.toggle_en;
				rd_word[smt_pkg::FORCE_HI_BIT:smt_pkg::FORCE_LO_BIT] =
					smt_pkg::FORCE_NOP;
				rd_word[smt_pkg::CLK_SEL_BIT] = st_r.clk_sel;
			end
			smt_pkg::ADDR_COMPARE: begin
				rd_word[15:0] = st_r.compare;
			end
			smt_pkg::ADDR_COUNT: begin
				rd_word[15:0] = count_val;
			end
			default: begin
				rd_word = 32'h00000000;
			end
		endcase
	end

	always_comb begin
		st_nxt           = st_r;
		st_nxt.tick_prev = pclk_s;
		// two-cycle handshake: capture, then answer
		case (st_r.bus)
			smt_pkg::BUS_IDLE: begin
				if (req) begin
					st_nxt.bus = smt_pkg::BUS_ACK;
					if (avs_read) begin
						st_nxt.rdata = rd_word;
					end
				end
			end
			smt_pkg::BUS_ACK: begin
				st_nxt.bus = smt_pkg::BUS_IDLE;
			end
			default: begin
				st_nxt.bus = smt_pkg::BUS_IDLE;
			end
		endcase
		if (lane0_wr & hit_en) begin
			st_nxt.idle_keep =
				avs_writedata[smt_pkg::IDLE_KEEP_BIT];
			st_nxt.halt_stop =
				avs_writedata[smt_pkg::HALT_STOP_BIT];
		end
		if (lane0_wr & hit_run) begin
			st_nxt.run = avs_writedata[smt_pkg::RUN_BIT];
		end
		if (lane0_wr & hit_cr) begin
			st_nxt.toggle_en =
				avs_writedata[smt_pkg::TOGGLE_EN_BIT];
			st_nxt.clk_sel = avs_writedata[smt_pkg::CLK_SEL_BIT];
		end
		if (lane0_wr & hit_cmp) begin
			st_nxt.compare[7:0] = avs_writedata[7:0];
		end
		if (lane1_wr & hit_cmp) begin
			st_nxt.compare[15:8] = avs_writedata[15:8];
		end
		// match toggle first, software force has the last word
		if (match_interrupt & st_r.toggle_en) begin
			st_nxt.sq_out = ~st_r.sq_out;
		end
		if (force_wr) begin
			case (force_code)
				smt_pkg::FORCE_INVERT: begin
					st_nxt.sq_out = ~st_nxt.sq_out;
				end
				smt_pkg::FORCE_SET: begin
					st_nxt.sq_out = 1'b1;
				end
				smt_pkg::FORCE_CLEAR: begin
					st_nxt.sq_out = 1'b0;
				end
				default: begin
					st_nxt.sq_out = st_nxt.sq_out;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= SMT_TOP_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign avs_readdata       = st_r.rdata;
	assign square_wave_output = st_r.sq_out;

	default clocking cb @(posedge sys_clk);
	endclocking

	default disable iff (!rst_n);

	chk_stop_freeze: assert property (
		!st_r.run && !ld_count |=> $stable(count_val)
	) else $error("count moved while stopped");

	chk_match_wrap: assert property (
		cnt_adv && count_val == st_r.compare
		|=> count_val == 16'h0000
	) else $error("count did not wrap on match");

	chk_count_step: assert property (
		cnt_adv && count_val != st_r.compare
		|=> count_val == $past(count_val) + 16'h0001
	) else $error("count did not step by one");

	chk_irq_on_match: assert property (
		cnt_adv && count_val == st_r.compare |=> match_interrupt
	) else $error("match interrupt missing");

	chk_irq_only_match: assert property (
		!(cnt_adv && count_val == st_r.compare) |=> !match_interrupt
	) else $error("match interrupt without match");

	chk_toggle_match: assert property (
		match_interrupt && st_r.toggle_en && !force_wr
		|=> square_wave_output != $past(square_wave_output)
	) else $error("output did not toggle on match");

	chk_toggle_off: assert property (
		!st_r.toggle_en && !force_wr |=> $stable(square_wave_output)
	) else $error("output changed with toggling off");

	chk_force_set: assert property (
		force_wr && force_code == smt_pkg::FORCE_SET
		|=> square_wave_output
	) else $error("force set failed");

	chk_force_clear: assert property (
		force_wr && force_code == smt_pkg::FORCE_CLEAR
		|=> !square_wave_output
	) else $error("force clear failed");

	chk_force_reads: assert property (
		avs_read && acc && hit_cr |-> avs_readdata[5:4] == 2'h3
	) else $error("force field did not read as 11");

	chk_idle_pause: assert property (
		(st_r.run && idle_block && !ld_count) [*2]
		|=> $stable(count_val)
	) else $error("count moved during idle pause");

	chk_halt_pause: assert property (
		halt_block && !ld_count |=> $stable(count_val)
	) else $error("count moved during debug halt");

	chk_sys_clock: assert property (
		st_r.run && !st_r.clk_sel && !idle_block && !halt_block &&
		!ld_count && count_val != st_r.compare
		|=> count_val == $past(count_val) + 16'h0001
	) else $error("count missed a system clock");

	chk_stop_hold: assert property (
		!st_r.run && !force_wr && !match_interrupt
		|=> $stable(square_wave_output)
	) else $error("output changed while stopped");

	chk_readback_live: assert property (
		avs_read && acc && hit_cnt
		|-> avs_readdata[15:0] == $past(count_val)
	) else $error("readback is not the live count");

endmodule : smt_top

// >>> pkg/smt_pkg.sv
package smt_pkg;

	// register byte offsets
	localparam logic [4:0] ADDR_POWER_STATE = 5'h00;
	localparam logic [4:0] ADDR_RUN_CONTROL = 5'h04;
	localparam logic [4:0] ADDR_OUT_CLK_CTRL = 5'h08;
	localparam logic [4:0] ADDR_COMPARE     = 5'h0C;
	localparam logic [4:0] ADDR_COUNT       = 5'h10;

	// field positions
	localparam int unsigned IDLE_KEEP_BIT  = 0;
	localparam int unsigned HALT_STOP_BIT  = 1;
	localparam int unsigned RUN_BIT        = 0;
	localparam int unsigned CLK_SEL_BIT    = 0;
	localparam int unsigned FORCE_LO_BIT   = 4;
	localparam int unsigned FORCE_HI_BIT   = 5;
	localparam int unsigned TOGGLE_EN_BIT  = 7;

	// output force codes
	localparam logic [1:0] FORCE_INVERT = 2'h0;
	localparam logic [1:0] FORCE_SET    = 2'h1;
	localparam logic [1:0] FORCE_CLEAR  = 2'h2;
	localparam logic [1:0] FORCE_NOP    = 2'h3;

	// reset values
	localparam logic        IDLE_KEEP_RST = 1'h0;
	localparam logic        HALT_STOP_RST = 1'h0;
	localparam logic        RUN_RST       = 1'h0;
	localparam logic        TOGGLE_EN_RST = 1'h0;
	localparam logic        CLK_SEL_RST   = 1'h0;
	localparam logic [15:0] COMPARE_RST   = 16'h0000;
	localparam logic [15:0] COUNT_RST     = 16'h0000;
	localparam logic        SQ_OUT_RST    = 1'h0;

	// synchroniser width: idle, debug halt, prescaled clock
	localparam int unsigned SYNC_W = 3;

	// bus handshake states
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK  = 2'b10
	} smt_bus_e;

endpackage : smt_pkg

// >>> testbench/smt_bench.sv
`timescale 1ns/1ns
module smt_bench;
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [3:0]  avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        idle_mode = 1'b0;
	logic        debug_halt = 1'b0;
	logic        periph_clk_prescaled = 1'b0;
	logic        square_wave_output;
	logic        match_interrupt;
	// reference model state
	logic [1:0]  m_pw;
	logic        m_run, m_match_toggle_enable, m_sel, m_sq, m_irq;
	logic [15:0] m_cmp, m_cnt, rd_cnt;
	logic [1:0]  frc;
	logic        tg;
	logic [2:0]  i_s, h_s, p_s;
	logic        adv;
	logic [31:0] q;
	logic [31:0] rnd = 32'hEFF90674;
	int          failures = 0;
	int          n_compared = 0;
	int          cyc = 0;

	always #10 sys_clk = ~sys_clk;

	smt_top DUT (.sys_clk, .rst_n, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
		.idle_mode, .debug_halt, .periph_clk_prescaled,
		.square_wave_output, .match_interrupt);

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic end_sim();
		$display("compared %0d, mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] v, input logic [31:0] e);
		n_compared++;
		if (v !== e) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, v, e);
		end
	endtask : chk

	// pause and tick conditions as the block should see them
	assign adv = m_run && (!m_sel || (p_s[1] && !p_s[2]))
		&& !(i_s[1] && !m_pw[0]) && !(h_s[1] && m_pw[1]);

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			{m_pw, m_run, m_match_toggle_enable, m_sel, m_sq, m_irq} <= '0;
			{m_cmp, m_cnt, rd_cnt} <= '0;
			{i_s, h_s, p_s} <= '0;
		end else begin
			chk(32'(match_interrupt), 32'(m_irq));
			chk(32'(square_wave_output), 32'(m_sq));
			i_s <= {i_s[1:0], idle_mode};
			h_s <= {h_s[1:0], debug_halt};
			p_s <= {p_s[1:0], periph_clk_prescaled};
			m_irq <= adv && m_cnt == m_cmp;
			if (adv)
				m_cnt <= (m_cnt == m_cmp) ? 16'h0000 : m_cnt + 16'h0001;
			// force lands at the accepting edge, after any toggle
			frc = smt_pkg::FORCE_NOP;
			if (avs_write && !avs_waitrequest && avs_byteenable[0]
				&& avs_address == smt_pkg::ADDR_OUT_CLK_CTRL)
				frc = avs_writedata[5:4];
			tg = m_sq ^ (m_irq && m_match_toggle_enable);
			if (frc == smt_pkg::FORCE_NOP)
				m_sq <= tg;
			else if (frc == smt_pkg::FORCE_INVERT)
				m_sq <= !tg;
			else
				m_sq <= (frc == smt_pkg::FORCE_SET);
			if (avs_read && avs_waitrequest && avs_address == smt_pkg::ADDR_COUNT)
				rd_cnt <= m_cnt;
		end
	end

	function automatic logic [31:0] exp_rd(input logic [4:0] a);
		case (a)
			smt_pkg::ADDR_POWER_STATE: return {30'h0, m_pw};
			smt_pkg::ADDR_RUN_CONTROL: return {31'h0, m_run};
			smt_pkg::ADDR_OUT_CLK_CTRL: return {24'h0, m_match_toggle_enable, 3'h3, 3'h0, m_sel};
			smt_pkg::ADDR_COMPARE: return {16'h0, m_cmp};
			smt_pkg::ADDR_COUNT: return {16'h0, rd_cnt};
			default: return 32'h00000000;
		endcase
	endfunction : exp_rd

	task automatic bus(input logic wr, input logic [4:0] a,
		input logic [31:0] d, input logic [3:0] be);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		avs_byteenable <= be;
		@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0)
			@(posedge sys_clk);
		q = avs_readdata;
		if (wr) begin
			case (a)
				smt_pkg::ADDR_POWER_STATE: m_pw <= d[1:0];
				smt_pkg::ADDR_RUN_CONTROL: m_run <= d[0];
				smt_pkg::ADDR_OUT_CLK_CTRL: begin
					m_match_toggle_enable <= d[7];
					m_sel <= d[0];
				end
				smt_pkg::ADDR_COMPARE: m_cmp <= {be[1] ? d[15:8] : m_cmp[15:8],
					be[0] ? d[7:0] : m_cmp[7:0]};
				smt_pkg::ADDR_COUNT: m_cnt <= d[15:0];
				default: ;
			endcase
		end
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge sys_clk);
	endtask : bus

	task automatic rd(input logic [4:0] a);
		bus(1'b0, a, 32'h00000000, 4'hF);
		chk(q, exp_rd(a));
	endtask : rd

	// random idle, halt and prescaled clock levels
	task automatic stim(input int n);
		repeat (n) begin
			@(posedge sys_clk);
			rnd = lfsr(rnd);
			idle_mode <= rnd[0];
			debug_halt <= rnd[1];
			periph_clk_prescaled <= rnd[2];
		end
	endtask : stim

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc > 8000) begin
			failures++;
			end_sim();
		end
	end

	initial begin
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		for (int a = 0; a <= 20; a += 4)
			rd(5'(a));
		bus(1'b1, 5'h14, 32'hFFFFFFFF, 4'hF);
		rd(5'h14);
		bus(1'b1, smt_pkg::ADDR_COMPARE, 32'h0000ABCD, 4'hF);
		bus(1'b1, smt_pkg::ADDR_COMPARE, 32'h00000012, 4'h1);
		rd(smt_pkg::ADDR_COMPARE);
		for (int i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			// setup only while stopped, count cleared last, just before the readback and run
			bus(1'b1, smt_pkg::ADDR_POWER_STATE, 32'(i & 3), 4'hF);
			bus(1'b1, smt_pkg::ADDR_OUT_CLK_CTRL,
				32'(((i & 1) << 7) | ((i & 3) << 4) | (i >> 2)), 4'hF);
			bus(1'b1, smt_pkg::ADDR_COMPARE, {28'h0, rnd[3:0]} + 32'h2, 4'hF);
			bus(1'b1, smt_pkg::ADDR_COUNT, 32'h00000000, 4'h3);
			for (int a = 0; a <= 16; a += 4)
				rd(5'(a));
			bus(1'b1, smt_pkg::ADDR_RUN_CONTROL, 32'h00000001, 4'hF);
			stim(60);
			rd(smt_pkg::ADDR_COUNT);
			stim(60);
			bus(1'b1, smt_pkg::ADDR_RUN_CONTROL, 32'h00000000, 4'hF);
			rd(smt_pkg::ADDR_COUNT);
			stim(6);
			rd(smt_pkg::ADDR_COUNT);
		end
		end_sim();
	end

endmodule : smt_bench
